// [pkg/avg_map.svh]
/*
  Constants for the sample averager: field widths, codes and limits.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef AVG_MAP_SVH
`define AVG_MAP_SVH
`define SAMPLE_WIDTH 12
`define SUM_WIDTH 16
`define COUNT_SEL_WIDTH 4
`define SHIFT_WIDTH 3
`define COUNT_SEL_MAX 4'ha
`define AUTO_SHIFT_START 4'h4
`define RES_AVERAGE 2'h1
`define FIFO_DEPTH 32
`endif

// [pkg/avg_pkg.sv]
/*
  Types for the sample averager.
  Assumes avg_map.svh on the include path.
*/
`include "avg_map.svh"
package avg_pkg;
  typedef struct packed
  {
    logic [`COUNT_SEL_WIDTH-1:0] sample_count_select;
    logic [`SHIFT_WIDTH-1:0] adjust_shift_count;
    logic [1:0] result_resolution_select;
  } averaging_control_type;
  typedef enum logic [0:0] {ST_ACCUM, ST_EMIT} avg_state_type;
endpackage : avg_pkg

// [hw/avg_fifo.sv]
/*
  Holds no logic: the sample FIFO module avg_fifo lives together with
  the averager in hw/adc_sample_averager.sv, the single design file.
  Assumes nothing of its surroundings.
*/

// [hw/adc_sample_averager.sv]
/*
  Result-averaging stage: accumulates raw samples, shifts, posts result.
  Assumes raw samples arrive synchronous to I_CLK with valid/ready.
*/
// Contract
// - Accumulate 1 << sample_count_select samples, codes 0x0 to 0xA; a result_resolution_select other than RES_AVERAGE takes one sample.
// - The result is the sum of m samples after the automatic shift, shifted right by adjust_shift_count.
// - Automatic right shift keeps the sum in 16 bits, 0 up to 16 samples.
// - The ready flag rises only when the full average is done.
// - One result per m raw conversions.
`timescale 1ns/100ps
`include "avg_map.svh"

// ****************************************
// Sample FIFO
// ****************************************
module avg_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic push, pop;

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("avg_fifo: DEPTH must be a power of two >= 2");
  end

  // ****************************************
  // Handshake
  // ****************************************
  assign push = i_valid && ready_reg;
  assign pop = o_valid && i_ready;
  assign o_ready = ready_reg;
  assign o_valid = cnt_reg != '0;
  assign o_data = mem[rd_reg];

  // ****************************************
  // Pointers and fill level
  // ****************************************
  always_comb
  begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Full flag registered so ready leaves a flip-flop
    ready_next = cnt_next != (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_reg] <= i_data;
    if (i_srst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end
endmodule : avg_fifo

// ****************************************
// Averager
// ****************************************
module adc_sample_averager
  import avg_pkg::*;
#(
  parameter int SAMPLE_W = `SAMPLE_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire averaging_control_type i_averaging_control,
  input wire logic i_result_ready_clear,
  output logic [`SUM_WIDTH-1:0] o_result,
  output logic o_result_ready_flag,
  output logic o_result_strobe
);
  initial
  begin
    if (SAMPLE_W != `SAMPLE_WIDTH)
      $error("adc_sample_averager: sample width must be 12");
  end

  // ****************************************
  // Sample buffer
  // ****************************************
  logic f_valid, f_ready;
  logic [SAMPLE_W-1:0] f_data;
  avg_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_valid(i_sample_valid),
    .o_ready(o_sample_ready),
    .i_data(i_sample),
    .o_valid(f_valid),
    .i_ready(f_ready),
    .o_data(f_data)
  );

  // ****************************************
  // Accumulation
  // ****************************************
  logic [`COUNT_SEL_WIDTH-1:0] sel;
  logic [3:0] auto_shift;
  logic [10:0] target;
  avg_state_type state_reg, state_next;
  logic [10:0] cnt_reg, cnt_next;
  // Room for 1024 full-scale samples
  localparam int ACC_W = SAMPLE_W + int'(`COUNT_SEL_MAX);
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [`SUM_WIDTH-1:0] res_reg, res_next;
  logic rdy_reg, rdy_next, stb_reg, stb_next;

  always_comb
  begin
    // Reserved codes act as a single sample
    sel = (i_averaging_control.sample_count_select > `COUNT_SEL_MAX)
      ? '0 : i_averaging_control.sample_count_select;
    if (i_averaging_control.result_resolution_select != `RES_AVERAGE)
      sel = '0;
    target = 11'(11'h1 << sel);
    auto_shift = (sel > `AUTO_SHIFT_START) ? sel - `AUTO_SHIFT_START
      : 4'h0;
  end

  assign f_ready = state_reg == ST_ACCUM;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    res_next = res_reg;
    rdy_next = rdy_reg;
    stb_next = 1'b0;
    if (i_result_ready_clear)
      rdy_next = 1'b0;
    case (state_reg)
      ST_ACCUM:
      begin
        if (f_valid)
        begin
          // Exact sum; the automatic shift is applied once at the end
          acc_next = acc_reg + ACC_W'(f_data);
          cnt_next = cnt_reg + 11'h1;
          if (cnt_next >= target)
            state_next = ST_EMIT;
        end
      end
      ST_EMIT:
      begin
        // Automatic shift brings the sum back into 16 bits
        res_next = `SUM_WIDTH'(acc_reg >> auto_shift);
        res_next = res_next >>
          i_averaging_control.adjust_shift_count;
        rdy_next = 1'b1;
        stb_next = 1'b1;
        acc_next = '0;
        cnt_next = '0;
        state_next = ST_ACCUM;
      end
      default:
        state_next = ST_ACCUM;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state_reg <= ST_ACCUM;
      cnt_reg <= '0;
      acc_reg <= '0;
      res_reg <= '0;
      rdy_reg <= 1'b0;
      stb_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      res_reg <= res_next;
      rdy_reg <= rdy_next;
      stb_reg <= stb_next;
    end
  end

  assign o_result = res_reg;
  assign o_result_ready_flag = rdy_reg;
  assign o_result_strobe = stb_reg;
endmodule : adc_sample_averager

// [verif/avg_properties.sv]
/* Timing checks on the averager outputs.
   Bound to adc_sample_averager by the bench. */
`timescale 1ns/100ps
`include "avg_map.svh"
module avg_properties
  import avg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic i_sample_valid,
  input wire logic o_sample_ready,
  input wire logic i_result_ready_clear,
  input wire logic [`SUM_WIDTH-1:0] o_result,
  input wire logic o_result_ready_flag,
  input wire logic o_result_strobe
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_pulse;
    o_result_strobe ##1 !o_result_strobe;
  endsequence
  a_strobe_one_cycle: assert property (o_result_strobe |-> s_pulse)
    else $error("strobe longer than one cycle");
  a_flag_with_strobe: assert property (o_result_strobe |-> o_result_ready_flag)
    else $error("flag low at result");
  a_flag_rise_cause: assert property ($rose(o_result_ready_flag) |-> o_result_strobe)
    else $error("flag rose without result");
  a_flag_clear_works: assert property (o_result_ready_flag && i_result_ready_clear
    |=> !o_result_ready_flag || o_result_strobe)
    else $error("flag not cleared");
  a_result_holds: assert property (!o_result_strobe |-> $stable(o_result))
    else $error("result changed without strobe");
  a_ready_fall_cause: assert property ($fell(o_sample_ready) |-> $past(i_sample_valid))
    else $error("ready fell without traffic");
endmodule : avg_properties

// [verif/adc_core_model.sv]
/* Converter core model: offers raw samples on valid/ready.
   Assumes the caller starts each burst at a falling edge. */
`timescale 1ns/100ps
module adc_core_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [11:0] o_data
);
  logic stall_seen = 1'b0;
  initial o_valid = 1'b0;
  initial o_data = 12'h0;
  task automatic send(int n, logic [11:0] base, logic [11:0] step);
    for (int i = 0; i < n; i++)
    begin
      o_valid = 1'b1;
      o_data = base + 12'(i) * step;
      while (!i_ready)
      begin
        stall_seen = 1'b1;
        @(negedge i_clk);
      end
      @(negedge i_clk);
    end
    o_valid = 1'b0;
    // Released bus shows the inverse
    o_data = ~o_data;
  endtask : send
endmodule : adc_core_model

// [verif/adc_sample_averager_tb.sv]
/* Self-checking bench for the averager.
   Assumes the design files and the core model are compiled first. */
`timescale 1ns/100ps
`include "avg_map.svh"
module adc_sample_averager_tb;
  import avg_pkg::*;
  logic clk = 0, srst = 1, clr = 0, vld, rdy, flag, stb;
  logic [11:0] dat;
  logic [15:0] res;
  averaging_control_type ctl = '0;
  int fails = 0, comparisons = 0, nstb = 0;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) nstb++;
  adc_core_model core (.i_clk(clk), .i_ready(rdy), .o_valid(vld),
    .o_data(dat));
  adc_sample_averager uut (.I_CLK(clk), .I_SRST(srst),
    .i_sample_valid(vld), .o_sample_ready(rdy), .i_sample(dat),
    .i_averaging_control(ctl), .i_result_ready_clear(clr),
    .o_result(res), .o_result_ready_flag(flag), .o_result_strobe(stb));
  task automatic end_of_test();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_avg(logic [3:0] sel, logic [2:0] adj, logic [1:0] r,
    int n, logic [11:0] base, logic [11:0] step);
    int s0, w, sum, a;
    sum = 0;
    for (int i = 0; i < n; i++) sum += int'(base) + i * int'(step);
    a = (sel > `AUTO_SHIFT_START && sel <= `COUNT_SEL_MAX) ? sel - 4 : 0;
    s0 = nstb;
    clr = 1'b1;
    ctl = '{sel, adj, r};
    @(negedge clk);
    clr = 1'b0;
    chk({15'h0, flag}, 16'h0);
    core.send(n, base, step);
    w = 0;
    while (flag !== 1'b1 && w < 200)
    begin
      @(negedge clk);
      w++;
    end
    if (w >= 200)
    begin
      fails++;
      $display("[FAIL] %0t no result within limit", $time);
    end
    // Let the strobe be counted and catch any extra result
    repeat (4) @(negedge clk);
    chk(res, 16'((sum >> a) >> adj));
    chk(16'(nstb - s0), 16'h1);
    $display("test sel %h res %h done", sel, r);
  endtask : t_avg
  task automatic t_fill();
    int s0;
    s0 = nstb;
    ctl = '{4'h0, 3'h0, `RES_AVERAGE};
    core.send(80, 12'h100, 12'h1);
    repeat (200) @(negedge clk);
    chk({15'h0, core.stall_seen}, 16'h1);
    chk(res, 16'h14f);
    chk(16'(nstb - s0), 16'd80);
    $display("test fifo fill done");
  endtask : t_fill
  initial
  begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    chk(res, 16'h0);
    chk({14'h0, flag, rdy}, 16'h1);
    t_avg(4'h0, 3'h0, `RES_AVERAGE, 1, 12'habc, 12'h0);
    t_avg(4'h2, 3'h2, `RES_AVERAGE, 4, 12'h0ff, 12'h3);
    t_avg(4'h4, 3'h4, `RES_AVERAGE, 16, 12'h7f0, 12'h1);
    t_avg(4'h5, 3'h4, `RES_AVERAGE, 32, 12'h800, 12'h0);
    t_avg(4'ha, 3'h4, `RES_AVERAGE, 1024, 12'hfff, 12'h0);
    t_avg(4'hb, 3'h0, `RES_AVERAGE, 1, 12'h123, 12'h0);
    t_avg(4'h3, 3'h0, 2'h0, 1, 12'h456, 12'h0);
    t_fill();
    end_of_test();
  end
  initial
  begin
    #50us;
    fails++;
    end_of_test();
  end
endmodule : adc_sample_averager_tb
bind adc_sample_averager avg_properties chk_i (.I_CLK, .I_SRST,
  .i_sample_valid, .o_sample_ready, .i_result_ready_clear, .o_result,
  .o_result_ready_flag, .o_result_strobe);
